// [hdl/tc16_regs.svh]
// register map, field positions and timing counts of the 16-bit timer
// assumes an 8-bit register port with byte-wide offsets
`ifndef TC16_REGS_SVH
`define TC16_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TC16_OFS_COUNT_LOW 8'h00
`define TC16_OFS_COUNT_HIGH 8'h01
`define TC16_OFS_IRQ_FLAGS 8'h02
`define TC16_OFS_IRQ_ENABLES 8'h03
`define TC16_OFS_CONTROL 8'h10

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TC16_BIT_RUN 0
`define TC16_BIT_CLK_SEL 1
`define TC16_BIT_SYNC_BYP 2
`define TC16_BIT_OSC_EN 3
`define TC16_PS_LO 4
`define TC16_PS_HI 5
`define TC16_CTRL_RESET 6'h00
`define TC16_CTRL_WMASK 8'h3f

// ----------------------------------------
// flag and enable registers, timing
// ----------------------------------------
`define TC16_BIT_OVF 0
`define TC16_COUNT_MAX 16'hffff
// the instruction cycle is four oscillator periods
`define TC16_INSTR_DIV 4

`endif

// [hdl/tc16_pkg.sv]
// types shared by the 16-bit timer modules
// assumes tc16_regs.svh is on the include path
`default_nettype none

package tc16_pkg;
    // ----------------------------------------
    // operating modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        TC16_TIMER,
        TC16_SYNC_CTR,
        TC16_ASYNC_CTR
    } tc16_mode_t;

    typedef logic [7:0] tc16_byte_t; // register port data
endpackage : tc16_pkg

`default_nettype wire

// [hdl/tc16_pin_sync.sv]
// two-stage synchroniser with edge detection for the count pins
// assumes pins are asynchronous to mclk; srst is synchronous
`default_nettype none

module tc16_pin_sync #(
    parameter int W = 2
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    import tc16_pkg::*;

    // ----------------------------------------
    // synchroniser and edge state
    // ----------------------------------------
    logic [W-1:0] meta; // first stage, read by stage two only
    logic [W-1:0] stage2; // safe level
    logic [W-1:0] next_level;
    logic [W-1:0] next_rise;
    logic [W-1:0] next_fall;

    // edges compare the safe level with its delayed copy
    always_comb begin
        next_level = stage2;
        next_rise = stage2 & ~level;
        next_fall = ~stage2 & level;
    end

    // reset low, so a pin high at release shows one rising edge
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta <= '0;
            stage2 <= '0;
            level <= '0;
            rise <= '0;
            fall <= '0;
        end else begin
            meta <= async_in;
            stage2 <= meta;
            level <= next_level;
            rise <= next_rise;
            fall <= next_fall;
        end
    end
endmodule : tc16_pin_sync

`default_nettype wire

// [hdl/tc16_timer.sv]
// 16-bit timer/counter with prescaler, overflow flag and trigger reset
// assumes one mclk domain (the oscillator clock) and an 8-bit reg port
`include "tc16_regs.svh"
`default_nettype none

module tc16_timer (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire tc16_pkg::tc16_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tc16_pkg::tc16_byte_t reg_rdata,
    input wire logic ext_count_input,
    input wire logic osc_input_pin,
    input wire logic [1:0] port_direction,
    input wire logic sleep_mode,
    input wire logic special_event_trig,
    output logic overflow_irq,
    output logic timebase_valid,
    output logic osc_power_on,
    output logic [1:0] pin_oe,
    output logic [1:0] pin_read
);
    import tc16_pkg::*;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // low prescaler bits that must be all ones for a carry
    function automatic logic [2:0] ps_mask(input logic [1:0] ps);
        ps_mask = {ps == 2'b11, ps[1], ps != 2'b00};
    endfunction : ps_mask

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ----------------------------------------
    // pin synchronisers: bit 0 ext pin, bit 1 osc pin
    // ----------------------------------------
    logic [1:0] pin_lvl; // synced levels
    logic [1:0] pin_rise; // one-cycle rising edges
    logic [1:0] pin_fall; // one-cycle falling edges

    tc16_pin_sync #(.W(2)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in({osc_input_pin, ext_count_input}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [5:0] ctrl; // implemented control bits
    logic [15:0] count; // count pair
    logic ovf_flag; // sticky overflow flag
    logic ovf_en; // overflow interrupt enable
    logic armed; // falling edge seen since enable
    logic [1:0] div; // fosc/4 divider
    logic [2:0] pre; // prescaler counter
    logic [5:0] next_ctrl;
    logic [15:0] next_count;
    logic next_ovf_flag;
    logic next_ovf_en;
    logic next_armed;
    logic [1:0] next_div;
    logic [2:0] next_pre;
    logic [7:0] next_rdata;
    logic next_irq;
    logic next_tb;
    logic next_osc_pwr;
    logic [1:0] next_pin_oe;
    logic [1:0] next_pin_read;

    // ----------------------------------------
    // control field views and strobes
    // ----------------------------------------
    logic run; // timer on
    logic clk_sel; // 1 = pin source
    logic osc_en; // crystal oscillator on
    tc16_mode_t mode; // operating mode
    logic src_rise; // selected pin rising edge
    logic src_fall; // selected pin falling edge
    logic tick; // instruction cycle tick
    logic cnt_event; // clock into the prescaler
    logic carry; // prescaler output
    logic inc; // count increment
    logic wr_low; // write to low byte
    logic wr_high; // write to high byte
    logic wr_cnt; // write to either byte
    logic ovf; // wrap this cycle

    always_comb begin
        run = ctrl[`TC16_BIT_RUN];
        clk_sel = ctrl[`TC16_BIT_CLK_SEL];
        osc_en = ctrl[`TC16_BIT_OSC_EN];
        // bypass only matters with the pin source
        if (!clk_sel) begin
            mode = TC16_TIMER;
        end else if (ctrl[`TC16_BIT_SYNC_BYP]) begin
            mode = TC16_ASYNC_CTR;
        end else begin
            mode = TC16_SYNC_CTR;
        end
        // oscillator pin replaces the ext pin
        src_rise = osc_en ? pin_rise[1] : pin_rise[0];
        src_fall = osc_en ? pin_fall[1] : pin_fall[0];
        tick = (div == 2'(`TC16_INSTR_DIV - 1));
        wr_low = reg_wr && hit(reg_addr, `TC16_OFS_COUNT_LOW);
        wr_high = reg_wr && hit(reg_addr, `TC16_OFS_COUNT_HIGH);
        wr_cnt = wr_low || wr_high;
        // fosc stops in sleep, the pin does not
        if (clk_sel) begin
            cnt_event = run && armed && src_rise;
        end else begin
            cnt_event = run && tick && !sleep_mode;
        end
        // prescaler sits ahead of the synchroniser stage
        carry = cnt_event && ((pre & ps_mask(ctrl[`TC16_PS_HI:`TC16_PS_LO]))
            == ps_mask(ctrl[`TC16_PS_HI:`TC16_PS_LO]));
        // synchroniser is off in sleep; async mode keeps going
        inc = carry && !(mode == TC16_SYNC_CTR && sleep_mode);
        ovf = inc && (count == `TC16_COUNT_MAX) && !wr_cnt
            && !special_event_trig;
    end

    // ----------------------------------------
    // next-state of counting logic
    // ----------------------------------------
    always_comb begin
        next_div = div + 2'h1;
        if (tick) begin
            next_div = 2'h0;
        end
        // re-arm whenever counter mode is left
        next_armed = (run && clk_sel) ? (armed || src_fall) : 1'b0;
        if (wr_cnt) begin
            next_pre = 3'h0;
        end else if (cnt_event) begin
            next_pre = pre + 3'h1;
        end else begin
            next_pre = pre;
        end
        next_count = count;
        if (wr_cnt) begin
            // write wins over both trigger and increment
            if (wr_low) begin
                next_count[7:0] = reg_wdata;
            end else begin
                next_count[15:8] = reg_wdata;
            end
        end else if (special_event_trig) begin
            next_count = 16'h0000;
        end else if (inc) begin
            next_count = count + 16'h0001;
        end
    end

    // count pair has no reset at all
    always_ff @(posedge mclk) begin
        count <= next_count;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div <= 2'h0;
            armed <= 1'b0;
            pre <= 3'h0;
        end else begin
            div <= next_div;
            armed <= next_armed;
            pre <= next_pre;
        end
    end

    // ----------------------------------------
    // register file and outputs
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_ovf_en = ovf_en;
        if (reg_wr && hit(reg_addr, `TC16_OFS_CONTROL)) begin
            next_ctrl = 6'(reg_wdata & `TC16_CTRL_WMASK);
        end
        if (reg_wr && hit(reg_addr, `TC16_OFS_IRQ_ENABLES)) begin
            next_ovf_en = reg_wdata[`TC16_BIT_OVF];
        end
        // set beats a same-cycle software clear
        next_ovf_flag = ovf_flag;
        if (reg_wr && hit(reg_addr, `TC16_OFS_IRQ_FLAGS)) begin
            next_ovf_flag = reg_wdata[`TC16_BIT_OVF];
        end
        if (ovf) begin
            next_ovf_flag = 1'b1;
        end
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `TC16_OFS_COUNT_LOW: next_rdata = count[7:0];
                `TC16_OFS_COUNT_HIGH: next_rdata = count[15:8];
                `TC16_OFS_IRQ_FLAGS: next_rdata = {7'h00, ovf_flag};
                `TC16_OFS_IRQ_ENABLES: next_rdata = {7'h00, ovf_en};
                `TC16_OFS_CONTROL: next_rdata = {2'b00, ctrl};
                default: next_rdata = 8'h00;
            endcase
        end
        next_irq = ovf_flag && ovf_en;
        next_tb = (mode != TC16_ASYNC_CTR);
        next_osc_pwr = osc_en;
        // oscillator takes both pins as inputs
        next_pin_oe = osc_en ? 2'b00 : ~port_direction;
        next_pin_read = osc_en ? 2'b00 : pin_lvl;
    end

    // control clears on every srst pulse
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl <= `TC16_CTRL_RESET;
            ovf_flag <= 1'b0;
            ovf_en <= 1'b0;
            reg_rdata <= 8'h00;
            overflow_irq <= 1'b0;
            timebase_valid <= 1'b1;
            osc_power_on <= 1'b0;
            pin_oe <= 2'b00;
            pin_read <= 2'b00;
        end else begin
            ctrl <= next_ctrl;
            ovf_flag <= next_ovf_flag;
            ovf_en <= next_ovf_en;
            reg_rdata <= next_rdata;
            overflow_irq <= next_irq;
            timebase_valid <= next_tb;
            osc_power_on <= next_osc_pwr;
            pin_oe <= next_pin_oe;
            pin_read <= next_pin_read;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    logic quiet; // no write and no trigger
    assign quiet = !wr_cnt && !special_event_trig;

    a_wrap_sets_flag: assert property (
        ovf |=> ovf_flag && count == 16'h0000)
        else $error("wrap did not set flag");
    a_irq_gated: assert property (
        ovf && ovf_en ##1 ovf_en |=> overflow_irq)
        else $error("enabled flag gave no irq");
    a_irq_masked: assert property (
        !ovf_en |=> !overflow_irq)
        else $error("masked irq raised");
    a_stopped_holds: assert property (
        !run && quiet |=> $stable(count))
        else $error("count moved while stopped");
    a_ctrl_top_zero: assert property (
        reg_rd && reg_addr == `TC16_OFS_CONTROL |=> reg_rdata[7:6] == 2'b00)
        else $error("control bits 7-6 not zero");
    a_unarmed_holds: assert property (
        clk_sel && !armed && quiet |=> $stable(count))
        else $error("count before falling edge");
    a_osc_pins_in: assert property (
        osc_en [*2] |-> pin_oe == 2'b00 && pin_read == 2'b00)
        else $error("osc pins not inputs");
    a_sleep_sync: assert property (
        mode == TC16_SYNC_CTR && sleep_mode && quiet |=> $stable(count))
        else $error("synced count moved in sleep");
    a_async_tb: assert property (
        mode == TC16_ASYNC_CTR |=> !timebase_valid)
        else $error("async mode gave time base");
    a_trig_clears: assert property (
        special_event_trig && !wr_cnt |=> count == 16'h0000)
        else $error("trigger did not clear count");
    a_write_wins: assert property (
        wr_low && special_event_trig |=> count[7:0] == $past(reg_wdata))
        else $error("trigger beat a write");
    a_presc_clear: assert property (
        wr_cnt |=> pre == 3'h0)
        else $error("prescaler not cleared");
    a_div_eight: assert property (
        inc && ctrl[5:4] == 2'b11 |-> pre == 3'h7)
        else $error("1:8 carry at wrong count");

    // flag lands one cycle after the wrap, the request one after that
    c_wrap: cover property (ovf ##2 overflow_irq);
    c_trig: cover property (special_event_trig && count != 16'h0000);
    c_async_sleep: cover property (mode == TC16_ASYNC_CTR && sleep_mode && inc);
endmodule : tc16_timer

`default_nettype wire

// [test/tc16_clk_src.sv]
// pulse source standing in for the count pin or the 32 kHz crystal
// assumes mclk from the bench; both pins rest low between bursts
`default_nettype none

module tc16_clk_src (
    input wire logic mclk,
    input wire logic go,
    input wire logic use_osc,
    input wire logic [4:0] n_edges,
    output logic ext_count_input,
    output logic osc_input_pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // burst of pulses, 3 mclk high, 3 mclk low
    // ----------------------------------------
    // three cycles keep each level above the two-cycle pin minimum
    initial begin
        ext_count_input = 1'b0;
        osc_input_pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge mclk);
            if (go) begin
                busy <= 1'b1;
                repeat (n_edges) begin
                    // only the chosen line moves, the other stands still
                    {osc_input_pin, ext_count_input} <= use_osc ? 2'b10 : 2'b01;
                    repeat (3) @(posedge mclk);
                    {osc_input_pin, ext_count_input} <= 2'b00;
                    repeat (3) @(posedge mclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : tc16_clk_src

`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the 16-bit timer, driven over its register port
// assumes tc16_regs.svh on the include path and the tc16_clk_src model
`include "tc16_regs.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tc16_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk, srst, reg_wr, reg_rd, sleep_mode, special_event_trig;
    logic [7:0] reg_addr;
    tc16_byte_t reg_wdata, reg_rdata, b;
    logic ext_count_input, osc_input_pin, overflow_irq, timebase_valid, osc_power_on;
    logic [1:0] port_direction, pin_oe, pin_read;
    logic go, use_osc, busy;
    logic [4:0] n_edges;
    logic [15:0] cnt;
    int miscompares, tests_run;
    // counter-mode table: control value, sleep flag, expected count
    tc16_byte_t ctl_tab [9] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h0b, 8'h07, 8'h03, 8'h07, 8'h02};
    logic [8:0] slp_tab = 9'b011000000;
    logic [15:0] exp_tab [9] = '{16'h10, 16'h8, 16'h4, 16'h2, 16'h10,
        16'h10, 16'h0, 16'h10, 16'h0};

    tc16_timer tc16_timer_i (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_count_input(ext_count_input), .osc_input_pin(osc_input_pin),
        .port_direction(port_direction), .sleep_mode(sleep_mode),
        .special_event_trig(special_event_trig), .overflow_irq(overflow_irq),
        .timebase_valid(timebase_valid), .osc_power_on(osc_power_on),
        .pin_oe(pin_oe), .pin_read(pin_read));

    tc16_clk_src tc16_clk_src_i (.mclk(mclk), .go(go), .use_osc(use_osc),
        .n_edges(n_edges), .ext_count_input(ext_count_input),
        .osc_input_pin(osc_input_pin), .busy(busy));

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input tc16_byte_t d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output tc16_byte_t d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rdc(output logic [15:0] v);
        tc16_byte_t h, l;
        rd(`TC16_OFS_COUNT_HIGH, h);
        rd(`TC16_OFS_COUNT_LOW, l);
        v = {h, l};
    endtask : rdc

    // bounded wait so a stuck source only costs 300 cycles
    task automatic send(input logic [4:0] k, input logic o);
        @(posedge mclk);
        go <= 1'b1;
        n_edges <= k;
        use_osc <= o;
        @(posedge mclk);
        go <= 1'b0;
        for (int i = 0; i < 300; i++) begin
            @(posedge mclk);
            #1;
            if (!busy) break;
        end
    endtask : send

    task automatic trig(input logic with_wr);
        @(posedge mclk);
        special_event_trig <= 1'b1;
        reg_wr <= with_wr;
        reg_addr <= `TC16_OFS_COUNT_LOW;
        reg_wdata <= 8'h33;
        @(posedge mclk);
        special_event_trig <= 1'b0;
        reg_wr <= 1'b0;
    endtask : trig

    task automatic rst();
        @(posedge mclk);
        srst <= 1'b1;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
    endtask : rst

    task automatic zero_count(input tc16_byte_t ctrl);
        wr(`TC16_OFS_CONTROL, 8'h00);
        wr(`TC16_OFS_COUNT_HIGH, 8'h00);
        wr(`TC16_OFS_COUNT_LOW, 8'h00);
        wr(`TC16_OFS_CONTROL, ctrl);
    endtask : zero_count

    // one ext pin pulse, port read looked at two cycles after the pin falls
    task automatic pin_peek(input tc16_byte_t c, input logic [1:0] e);
        wr(`TC16_OFS_CONTROL, c);
        @(posedge mclk);
        go <= 1'b1;
        n_edges <= 5'd1;
        use_osc <= 1'b0;
        @(posedge mclk);
        go <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        chk(pin_read, e, "pin read");
        repeat (4) @(posedge mclk);
    endtask : pin_peek

    // one arming pulse, then 16 edges, count read after stopping
    task automatic run_ctr(input int i);
        zero_count(ctl_tab[i]);
        repeat (2) @(posedge mclk);
        #1;
        chk(timebase_valid, !(ctl_tab[i][2] && ctl_tab[i][1]), "time base");
        chk(osc_power_on, ctl_tab[i][3], "osc power");
        chk(pin_oe, 2'(ctl_tab[i][3] ? 2'b00 : ~port_direction), "pin dir");
        send(5'd1, ctl_tab[i][3]);
        rdc(cnt);
        chk(cnt, 16'h0, "armed");
        @(posedge mclk);
        sleep_mode <= slp_tab[i];
        send(5'd16, ctl_tab[i][3]);
        repeat (8) @(posedge mclk);
        sleep_mode <= 1'b0;
        wr(`TC16_OFS_CONTROL, 8'h00);
        rdc(cnt);
        chk(cnt, exp_tab[i], "edge count");
        $display("counter case %0d done", i);
    endtask : run_ctr

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // the whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        {srst, reg_wr, reg_rd, sleep_mode, special_event_trig, go, use_osc} = 7'h44;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        n_edges = 5'd0;
        port_direction = 2'b01;
        // trigger under reset gives the unreset count pair a known start
        repeat (2) @(posedge mclk);
        special_event_trig <= 1'b0;
        rst();
        rd(`TC16_OFS_CONTROL, b);
        chk(b, 8'h00, "control reset");
        rd(`TC16_OFS_IRQ_FLAGS, b);
        chk(b, 8'h00, "flag reset");
        rd(8'h20, b);
        chk(b, 8'h00, "unmapped");
        $display("reset test done");
        // timer mode from ffff-1, bypass bit set must not matter
        wr(`TC16_OFS_COUNT_LOW, 8'hfe);
        wr(`TC16_OFS_COUNT_HIGH, 8'hff);
        wr(`TC16_OFS_IRQ_ENABLES, 8'h01);
        wr(`TC16_OFS_CONTROL, 8'h05);
        repeat (40) @(posedge mclk);
        #1;
        chk(timebase_valid, 1'b1, "timer base");
        wr(`TC16_OFS_CONTROL, 8'h00);
        rdc(cnt);
        chk(cnt[15:8], 16'h0, "wrapped");
        rd(`TC16_OFS_IRQ_FLAGS, b);
        chk(b, 8'h01, "flag set");
        chk(overflow_irq, 1'b1, "irq on");
        wr(`TC16_OFS_IRQ_ENABLES, 8'h00);
        repeat (2) @(posedge mclk);
        #1;
        chk(overflow_irq, 1'b0, "irq masked");
        wr(`TC16_OFS_IRQ_FLAGS, 8'h00);
        rd(`TC16_OFS_IRQ_FLAGS, b);
        chk(b, 8'h00, "flag cleared");
        $display("timer wrap test done");
        for (int i = 0; i < 9; i++) begin
            run_ctr(i);
        end
        // four edges into a 1:8 prescaler, write, four more: no increment
        zero_count(8'h33);
        send(5'd1, 1'b0);
        send(5'd4, 1'b0);
        wr(`TC16_OFS_COUNT_LOW, 8'h00);
        send(5'd4, 1'b0);
        repeat (8) @(posedge mclk);
        wr(`TC16_OFS_CONTROL, 8'h00);
        rdc(cnt);
        chk(cnt, 16'h0, "prescaler cleared");
        $display("prescaler clear test done");
        pin_peek(8'h00, 2'b01);
        pin_peek(8'h08, 2'b00);
        $display("pin read test done");
        wr(`TC16_OFS_COUNT_HIGH, 8'h5a);
        wr(`TC16_OFS_COUNT_LOW, 8'h10);
        trig(1'b0);
        rdc(cnt);
        chk(cnt, 16'h0, "trigger clear");
        wr(`TC16_OFS_COUNT_HIGH, 8'h5a);
        trig(1'b1);
        rdc(cnt);
        chk(cnt, 16'h5a33, "write wins");
        $display("trigger test done");
        wr(`TC16_OFS_CONTROL, 8'hff);
        rd(`TC16_OFS_CONTROL, b);
        chk(b, 8'h3f, "upper bits");
        wr(`TC16_OFS_COUNT_HIGH, 8'h12);
        wr(`TC16_OFS_COUNT_LOW, 8'h34);
        rst();
        rd(`TC16_OFS_CONTROL, b);
        chk(b, 8'h00, "control cleared");
        rdc(cnt);
        chk(cnt, 16'h1234, "count kept");
        $display("second reset test done");
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
